// ### design/sac_pkg.sv
// package: constants, types and state for the converter control block
package sac_pkg;
	// ==========================================================
	// clock and timing
	localparam int CLK_MHZ = 250;
	localparam int STEP_NS = 68;
	localparam int STEP_CYC = (STEP_NS * CLK_MHZ + 999) / 1000;
	localparam logic [4:0] STEP_LAST = 5'(STEP_CYC - 1);
	// ==========================================================
	// result word
	localparam int RES_W = 14;
	localparam logic [3:0] MSB_IDX = 4'hD;
	localparam logic [RES_W-1:0] APPROX_RST = 14'h0000;
	localparam logic [RES_W-1:0] LATCH_RST = 14'h0000;
	localparam logic [2:0] SYNC_RST = 3'h7;
	// ==========================================================
	// types
	typedef struct packed {
		logic cs_n;
		logic convert_start_n;
		logic rd_n;
		logic pd_n;
	} sac_pins_t;
	localparam sac_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1};
	typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DONE, ST_OFF} sac_state_t;
endpackage

// ### design/sac_top.sv
// converter control: start, bit sequencing, output latch, bus and shutdown
// ==========================================================
// Overview of operation
// - falling convert_start_n with device_select_n low starts a conversion
// - start and read pins are ignored while device_select_n is high
// - result bus driven only while read_strobe_n and device_select_n low
// - power_down_n low puts the block in shutdown
// - shutdown entry with select low gives nap, select high gives sleep
// - busy_n low through the whole conversion, high again at its end
// - result latched no later than the rising edge of busy_n
// - approximation register cleared at each conversion start
// - a running conversion ignores new start requests
// - fourteen bits decided one per step, most significant first
// - finished word copied into the output latches at conversion end
// - bit steps timed from the local clock, no host clock
// - result presented as two's complement
`timescale 1ns/100ps
module sac_top (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// host pins
	input wire sac_pkg::sac_pins_t pins_n,
	// comparator decision, high when input exceeds trial level
	input wire logic comp_above,
	// result bus
	output logic [sac_pkg::RES_W-1:0] result_bus,
	output logic result_bus_oe,
	output logic busy_n,
	// shutdown status
	output logic nap_mode,
	output logic sleep_mode,
	// result stream
	output logic [sac_pkg::RES_W-1:0] res_data,
	output logic res_valid,
	input wire logic res_ready
);
	import sac_pkg::*;

	function automatic logic [RES_W-1:0] set_bit(
		input logic [RES_W-1:0] w, input logic [3:0] i, input logic v);
		logic [RES_W-1:0] r;
		r = w;
		r[i] = v;
		return r;
	endfunction

	// ==========================================================
	// pin synchronisers: three stages, change taken when 2nd and 3rd agree
	logic [2:0] sync_q [4];
	logic [2:0] sync_d [4];
	sac_pins_t pf_q, pf_d, pfp_q, pfp_d;

	always_comb begin
		for (int k = 0; k < 4; k++) begin
			sync_d[k] = {sync_q[k][1:0], pins_n[k]};
		end
		pf_d = pf_q;
		for (int k = 0; k < 4; k++) begin
			if (sync_q[k][1] == sync_q[k][2]) begin
				pf_d[k] = sync_q[k][2];
			end
		end
		pfp_d = pf_q;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int k = 0; k < 4; k++) begin
				sync_q[k] <= SYNC_RST;
			end
			pf_q <= PINS_IDLE;
			pfp_q <= PINS_IDLE;
		end else begin
			sync_q <= sync_d;
			pf_q <= pf_d;
			pfp_q <= pfp_d;
		end
	end

	logic sel, start_fall, pd_fall;
	assign sel = !pf_q.cs_n;
	// chip select gates the start edge
	assign start_fall = sel && pfp_q.convert_start_n
		&& !pf_q.convert_start_n;
	assign pd_fall = pfp_q.pd_n && !pf_q.pd_n;

	// ==========================================================
	// two-entry result buffer
	logic [RES_W-1:0] head_q, head_d, tail_q, tail_d;
	logic head_v_q, head_v_d, tail_v_q, tail_v_d;
	logic push, buf_ready;
	logic [RES_W-1:0] push_word;
	// full only when both entries hold words; a stalled reader holds DONE
	assign buf_ready = !tail_v_q;

	always_comb begin
		head_d = head_q;
		tail_d = tail_q;
		head_v_d = head_v_q;
		tail_v_d = tail_v_q;
		if (head_v_q && res_ready) begin
			head_d = tail_q;
			head_v_d = tail_v_q;
			tail_v_d = 1'b0;
		end
		if (push) begin
			if (!head_v_d) begin
				head_d = push_word;
				head_v_d = 1'b1;
			end else begin
				tail_d = push_word;
				tail_v_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			head_q <= LATCH_RST;
			tail_q <= LATCH_RST;
			head_v_q <= 1'b0;
			tail_v_q <= 1'b0;
		end else begin
			head_q <= head_d;
			tail_q <= tail_d;
			head_v_q <= head_v_d;
			tail_v_q <= tail_v_d;
		end
	end

	assign res_data = head_q;
	assign res_valid = head_v_q;

	// ==========================================================
	// conversion sequencer
	sac_state_t state_q, state_d;
	logic [RES_W-1:0] approx_result_reg_q, approx_result_reg_d;
	logic [RES_W-1:0] latch_q, latch_d;
	logic [3:0] bit_idx_q, bit_idx_d;
	logic [4:0] step_q, step_d;
	logic busy_n_q, busy_n_d, oe_q, oe_d;
	logic nap_q, nap_d, sleep_q, sleep_d;

	// offset binary from the search, sign bit flipped on the way out
	assign push_word = {!approx_result_reg_q[RES_W-1],
		approx_result_reg_q[RES_W-2:0]};
	assign push = (state_q == ST_DONE) && buf_ready && pf_q.pd_n;

	always_comb begin
		state_d = state_q;
		approx_result_reg_d = approx_result_reg_q;
		latch_d = latch_q;
		bit_idx_d = bit_idx_q;
		step_d = step_q;
		nap_d = nap_q;
		sleep_d = sleep_q;
		if (!pf_q.pd_n) begin
			// shutdown aborts any conversion in flight
			state_d = ST_OFF;
			if (pd_fall) begin
				nap_d = sel;
				sleep_d = !sel;
			end
		end else begin
			unique case (state_q)
				ST_OFF: begin
					state_d = ST_IDLE;
					nap_d = 1'b0;
					sleep_d = 1'b0;
				end
				ST_IDLE: begin
					if (start_fall) begin
						state_d = ST_CONV;
						// cleared, then first trial bit set
						approx_result_reg_d = set_bit(APPROX_RST,
							MSB_IDX, 1'b1);
						bit_idx_d = MSB_IDX;
						step_d = STEP_LAST;
					end
				end
				ST_CONV: begin
					// new start edges are not looked at here
					if (step_q != 5'h00) begin
						step_d = step_q - 5'h01;
					end else begin
						approx_result_reg_d = set_bit(
							approx_result_reg_q, bit_idx_q,
							comp_above);
						if (bit_idx_q == 4'h0) begin
							state_d = ST_DONE;
						end else begin
							bit_idx_d = bit_idx_q - 4'h1;
							approx_result_reg_d = set_bit(
								approx_result_reg_d,
								bit_idx_d, 1'b1);
							step_d = STEP_LAST;
						end
					end
				end
				ST_DONE: begin
					// waits here while the buffer is full
					if (push) begin
						latch_d = push_word;
						state_d = ST_IDLE;
					end
				end
			endcase
		end
		// busy rises on the same edge that loads the latch
		busy_n_d = !(state_d == ST_CONV || state_d == ST_DONE);
		oe_d = sel && !pf_q.rd_n;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			approx_result_reg_q <= APPROX_RST;
			latch_q <= LATCH_RST;
			bit_idx_q <= MSB_IDX;
			step_q <= STEP_LAST;
			busy_n_q <= 1'b1;
			oe_q <= 1'b0;
			nap_q <= 1'b0;
			sleep_q <= 1'b0;
		end else begin
			state_q <= state_d;
			approx_result_reg_q <= approx_result_reg_d;
			latch_q <= latch_d;
			bit_idx_q <= bit_idx_d;
			step_q <= step_d;
			busy_n_q <= busy_n_d;
			oe_q <= oe_d;
			nap_q <= nap_d;
			sleep_q <= sleep_d;
		end
	end

	// reads in mid conversion see the old latch
	assign result_bus = latch_q;
	assign result_bus_oe = oe_q;
	assign busy_n = busy_n_q;
	assign nap_mode = nap_q;
	assign sleep_mode = sleep_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_start_clears: assert property (start_fall
		&& state_q == ST_IDLE && pf_q.pd_n |=> state_q == ST_CONV
		&& approx_result_reg_q == 14'h2000 && bit_idx_q == 4'hD)
		else $error("start edge did not begin a cleared conversion");
	a_select_gate: assert property (pf_q.cs_n
		&& state_q == ST_IDLE && pf_q.pd_n |=> state_q == ST_IDLE)
		else $error("conversion began without select");
	a_bus_enable: assert property (
		oe_q == $past(sel && !pf_q.rd_n))
		else $error("bus enable does not follow read and select");
	a_bus_idle: assert property (
		pf_q.cs_n || pf_q.rd_n |=> !oe_q)
		else $error("bus driven without read and select");
	a_power_down: assert property (
		!pf_q.pd_n |=> state_q == ST_OFF)
		else $error("power down did not reach shutdown");
	a_mode_pick: assert property (pd_fall
		|=> nap_q == $past(sel) && sleep_q == !$past(sel))
		else $error("wrong shutdown mode chosen");
	a_busy_conv: assert property (busy_n_q
		== !(state_q == ST_CONV || state_q == ST_DONE))
		else $error("busy does not track conversion");
	a_busy_hold: assert property ($fell(busy_n_q)
		&& pf_q.pd_n |-> !busy_n_q [*8])
		else $error("busy pulse too short");
	// the last decision must hand over to the wait, busy still low
	a_conv_end: assert property (state_q == ST_CONV
		&& step_q == 5'h00 && bit_idx_q == 4'h0 && pf_q.pd_n
		|=> state_q == ST_DONE && !busy_n_q)
		else $error("last bit did not end the conversion");
	a_no_restart: assert property (state_q == ST_CONV
		&& step_q != 5'h00 && pf_q.pd_n
		|=> $stable(bit_idx_q) && state_q == ST_CONV)
		else $error("running conversion disturbed");
	a_latch_load: assert property ($rose(busy_n_q)
		&& $past(state_q) == ST_DONE |-> latch_q == $past(push_word))
		else $error("latch not loaded at busy rise");
	a_latch_hold: assert property (state_q == ST_CONV
		|=> $stable(latch_q))
		else $error("latch changed during conversion");
	a_bit_step: assert property (state_q == ST_CONV
		&& step_q == 5'h00 && bit_idx_q != 4'h0 && pf_q.pd_n
		|=> bit_idx_q == $past(bit_idx_q) - 4'h1)
		else $error("bit order broken");
	a_step_reload: assert property (state_q == ST_CONV
		&& step_q == 5'h00 && bit_idx_q != 4'h0 && pf_q.pd_n
		|=> step_q == STEP_LAST)
		else $error("bit step not reloaded");

	c_full_conv: cover property ($rose(busy_n_q));
	c_stall: cover property (state_q == ST_DONE && !buf_ready);
	c_restart_seen: cover property (state_q == ST_CONV && sel
		&& pfp_q.convert_start_n && !pf_q.convert_start_n);
	c_nap: cover property ($rose(nap_q));
	c_sleep: cover property ($rose(sleep_q));
endmodule

// ### verification/sac_host_model.sv
// host and comparator model facing the converter control block
`timescale 1ns/100ps
module sac_host_model (
	// clock
	input wire logic clk,
	// converter side
	input wire logic busy_n,
	input wire logic res_valid,
	output logic comp_above,
	output logic res_ready,
	// bench control
	input wire logic [sac_pkg::RES_W-1:0] code,
	input wire logic stall
);
	import sac_pkg::*;
	int unsigned cnt_q = 0;
	// ==========================================================
	// comparator: one decision per step, msb first
	always @(posedge clk) begin
		if (busy_n === 1'b1) begin
			cnt_q <= 0;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
	// held over the whole step, so the sampling cycle need not be exact
	always_comb begin
		comp_above = (cnt_q < RES_W * STEP_CYC)
			? code[RES_W - 1 - cnt_q / STEP_CYC] : 1'b0;
	end
	// ==========================================================
	// reader: random stalls, full stall on request
	always @(negedge clk) begin
		res_ready <= !stall
			&& (res_valid !== 1'b1 || $urandom_range(3) != 0);
	end
endmodule

// ### verification/sac_top_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module sac_top_tb;
	import sac_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	sac_pins_t pins = PINS_IDLE;
	logic comp_above, res_ready, result_bus_oe, busy_n;
	logic nap_mode, sleep_mode, res_valid;
	logic stall = 1'b0;
	logic [RES_W-1:0] code = 14'h0000;
	logic [RES_W-1:0] result_bus, res_data;
	logic [RES_W-1:0] last_q = 14'h0000;
	logic [RES_W-1:0] exp_q[$];
	logic [RES_W-1:0] corner[3] = '{14'h3FFF, 14'h0000, 14'h2AAA};
	int errors = 0;
	int n_tests = 0;
	always #2 clk = ~clk;
	// ==========================================================
	// instances
	sac_top sac_top_inst (.clk(clk), .sys_rst(sys_rst), .pins_n(pins),
		.comp_above(comp_above), .result_bus(result_bus),
		.result_bus_oe(result_bus_oe), .busy_n(busy_n),
		.nap_mode(nap_mode), .sleep_mode(sleep_mode), .res_data(res_data),
		.res_valid(res_valid), .res_ready(res_ready));
	sac_host_model sac_host_model_inst (.clk(clk), .busy_n(busy_n),
		.res_valid(res_valid), .comp_above(comp_above),
		.res_ready(res_ready), .code(code), .stall(stall));
	// ==========================================================
	// expectation and stream scoreboard
	// search result with msb inverted gives two's complement
	function automatic logic [RES_W-1:0] exp_word(logic [RES_W-1:0] w);
		return w ^ 14'h2000;
	endfunction
	always @(posedge clk) begin
		if (!sys_rst && res_valid === 1'b1 && res_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				`CHK(1'b1, 1'b0)
			end else begin
				`CHK(res_data, exp_q[0])
				void'(exp_q.pop_front());
			end
		end
	end
	// ==========================================================
	// tasks
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_busy(logic lvl, int bound);
		int cnt;
		cnt = 0;
		while (busy_n !== lvl && cnt < bound) begin
			@(negedge clk);
			cnt++;
		end
		if (busy_n !== lvl) begin
			errors++;
			report_and_stop();
		end
	endtask
	// restart drops the start pin again mid-run; full checks the held DONE, then releases the stalled reader
	task automatic convert(logic [RES_W-1:0] w, logic restart, logic full);
		time t0;
		int n_cyc;
		code = w;
		pins.convert_start_n = 1'b0;
		wait_busy(1'b0, 12);
		t0 = $time;
		exp_q.push_back(exp_word(w));
		cyc(40);
		pins.rd_n = 1'b0;
		pins.convert_start_n = 1'b1;
		cyc(8);
		`CHK(result_bus_oe, 1'b1)
		`CHK(result_bus, last_q)
		pins.rd_n = 1'b1;
		pins.convert_start_n = !restart;
		if (full) begin
			cyc(400);
			`CHK({busy_n, res_valid}, 2'b01)
			stall = 1'b0;
		end
		wait_busy(1'b1, 2000);
		// steps plus one wait cycle, one more for the sampling phase
		n_cyc = int'(($time - t0) / 4) - RES_W * STEP_CYC;
		if (!full) `CHK(n_cyc inside {[1:2]}, 1'b1)
		`CHK(result_bus, exp_word(w))
		`CHK(result_bus_oe, 1'b0)
		last_q = exp_word(w);
		pins.convert_start_n = 1'b1;
		cyc(60);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(32'h5bba));
		cyc(12);
		sys_rst = 1'b0;
		`CHK({result_bus, result_bus_oe, busy_n, nap_mode, sleep_mode,
			res_valid}, {14'h0000, 5'h08})
		pins.cs_n = 1'b0;
		cyc(4);
		foreach (corner[i]) convert(corner[i], 1'b0, 1'b0);
		for (int i = 0; i < 4; i++) convert(14'($urandom), i[0], 1'b0);
		$display("test conversions done");
		pins.cs_n = 1'b1;
		cyc(2);
		pins.convert_start_n = 1'b0;
		pins.rd_n = 1'b0;
		cyc(12);
		`CHK({busy_n, result_bus_oe}, 2'b10)
		pins = PINS_IDLE;
		$display("test deselected done");
		for (int i = 0; i < 2; i++) begin
			pins.cs_n = i[0];
			cyc(6);
			pins.pd_n = 1'b0;
			cyc(8);
			`CHK({nap_mode, sleep_mode}, {~i[0], i[0]})
			pins.cs_n = 1'b0;
			pins.convert_start_n = 1'b0;
			cyc(12);
			`CHK(busy_n, 1'b1)
			pins.convert_start_n = 1'b1;
			pins.pd_n = 1'b1;
			cyc(8);
			`CHK({nap_mode, sleep_mode}, 2'b00)
		end
		$display("test shutdown done");
		stall = 1'b1;
		cyc(2);
		convert(14'($urandom), 1'b0, 1'b0);
		stall = 1'b1;
		convert(14'($urandom), 1'b0, 1'b0);
		stall = 1'b1;
		convert(14'($urandom), 1'b1, 1'b1);
		for (int i = 0; i < 200 && exp_q.size() != 0; i++) cyc(1);
		`CHK(exp_q.size(), 0)
		$display("test buffer done");
		report_and_stop();
	end
endmodule
